//--- hdl/nrmc_pkg.sv
// package: register map, field layout and codes for the receive mode control block
package nrmc_pkg;
	localparam logic [11:0] IDX_RX_MODE     = 12'h013;     // receive_mode_config word index
	localparam logic [11:0] ADDR_RX_MODE    = IDX_RX_MODE << 2; // byte address, one word per index
	localparam logic [11:0] ADDR_RX_CONTROL = 12'h000;     // command and receiver control word
	localparam logic [11:0] ADDR_RX_STATUS  = 12'h004;     // receiver status word
	localparam logic [7:0]  MODE_RESET      = 8'h00;       // receive_mode_config after reset
	localparam int          BIT_CRC_EN      = 7;           // receive_crc_enable
	localparam int          RATE_MSB        = 6;           // receive_rate_select top bit
	localparam int          RATE_LSB        = 4;           // receive_rate_select low bit
	localparam int          BIT_IGN_SHORT   = 3;           // ignore_short_burst
	localparam int          BIT_MULTI       = 2;           // multiple_frame_receive
	localparam int          FRAME_MSB       = 1;           // receive_framing_select top bit
	localparam int          FRAME_LSB       = 0;           // receive_framing_select low bit
	localparam int          CMD_MSB         = 3;           // command code field top bit
	localparam logic [3:0]  CMD_IDLE        = 4'h0;        // idle command code
	localparam logic [3:0]  CMD_RECEIVE     = 4'h8;        // receive command code
	localparam logic [3:0]  CMD_TRANSCEIVE  = 4'hc;        // transceive command code
	localparam logic [2:0]  RATE_106        = 3'h0;        // 106 kbit/s
	localparam logic [2:0]  RATE_212        = 3'h1;        // 212 kbit/s
	localparam logic [2:0]  RATE_424        = 3'h2;        // 424 kbit/s
	localparam logic [2:0]  RATE_848        = 3'h3;        // 848 kbit/s, highest supported
	localparam logic [1:0]  FRAME_TYPE_A    = 2'h0;        // type A framing
	localparam logic [1:0]  FRAME_TYPE_B    = 2'h3;        // type B framing
	localparam int          SHORT_BITS      = 4;           // invalid bursts below this are dropped
	localparam int          BIT_INV_FLAG    = 2;           // status word: sticky invalid flag
	localparam logic [15:0] CRC_PRESET_A    = 16'h6363;    // crc start value, type A framing
	localparam logic [15:0] CRC_PRESET_B    = 16'hffff;    // crc start value, type B framing
	typedef enum logic [1:0] {
		NRMC_IDLE,
		NRMC_ACTIVE,
		NRMC_DONE
	} nrmc_state_t;
endpackage

//--- hdl/nrmc_crc.sv
// file: crc-16 accumulator over received bytes
`timescale 1ns/10ps
module nrmc_crc #(
	parameter logic [15:0] PRESET = 16'h6363      // preset value, type dependent
) (
	input  wire logic        clock,               // system clock
	input  wire logic        arst_n,              // async reset, active low
	input  wire logic        clear,               // load preset at frame start
	input  wire logic        enable,              // byte accepted for crc
	input  wire logic [7:0]  data,                // received byte
	input  wire logic [15:0] preset_val,          // preset chosen by framing
	output logic      [15:0] crc                  // running crc
);
	logic [15:0] crc_reg;                         // running value
	logic [15:0] crc_next;                        // next value

	// bitwise reflected ccitt update, one byte per accepted cycle
	always_comb begin
		logic [15:0] c;
		c = crc_reg;
		if (clear) begin
			c = preset_val;
		end else if (enable) begin
			for (int i = 0; i < 8; i++) begin
				if (c[0] ^ data[i]) begin
					c = (c >> 1) ^ 16'h8408;
				end else begin
					c = c >> 1;
				end
			end
		end
		crc_next = c;
	end

	// register the crc
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			crc_reg <= PRESET;
		end else begin
			crc_reg <= crc_next;
		end
	end

	assign crc = crc_reg;
endmodule

//--- hdl/nrmc_top.sv
// file: receive mode configuration register and receiver control over apb
//
// Design decisions made here: the register offsets and the APB interface to the registers.
`timescale 1ns/10ps
// Notes on behaviour
// [R1] rate field picks 106 to 848 kbit/s
// [R2] ignore short invalid bursts, stay active
// [R3] single frame mode stops after one frame
// [R4] multiple frame mode keeps receiving frames
// [R5] non-receive command or clearing bit stops
// [R6] framing field picks type A or B
// [R7] crc enable computes crc over received data
module nrmc_top (
	input  wire logic        clock,               // 200 MHz system clock
	input  wire logic        arst_n,              // async reset, active low
	input  wire logic        psel,                // apb select
	input  wire logic        penable,             // apb access phase
	input  wire logic        pwrite,              // apb direction
	input  wire logic [11:0] paddr,               // apb byte address
	input  wire logic [31:0] pwdata,              // apb write data
	output logic      [31:0] prdata,              // apb read data
	output logic             pready,              // apb ready
	output logic             pslverr,             // apb error for unmapped address
	input  wire logic        rx_byte_valid,       // demodulator byte strobe
	input  wire logic [7:0]  rx_byte,             // demodulator byte
	input  wire logic        rx_frame_end,        // demodulator frame complete
	input  wire logic        rx_invalid,          // demodulator invalid stream seen
	input  wire logic [3:0]  rx_bit_count,        // bits in the invalid stream
	output logic             receiver_active,     // receiver running
	output logic [2:0]       rate_sel,            // decoded rate to demodulator
	output logic             framing_b,           // 1 for type B framing
	output logic             crc_on,              // crc checking enabled
	output logic [15:0]      crc_value,           // crc of last frame
	output logic             invalid_flag         // reported invalid stream, sticky
);
	logic [7:0]           mode_reg, mode_next;          // receive_mode_config
	logic [3:0]           cmd_reg, cmd_next;            // command code
	nrmc_pkg::nrmc_state_t st_reg, st_next;             // receiver state
	logic                 inv_reg, inv_next;            // sticky invalid stream flag
	logic [31:0]          rdata_reg, rdata_next;        // read data register
	logic                 rdy_reg, rdy_next;            // ready register
	logic                 err_reg, err_next;            // error register
	logic [2:0]           rate_reg, rate_next;          // rate to demodulator
	logic                 fb_reg, fb_next;              // framing to demodulator
	logic [15:0]          crcv_reg, crcv_next;          // latched crc
	logic                 bv_s1, bv_s2, fe_s1, fe_s2;   // pin synchronisers
	logic                 iv_s1, iv_s2;                 // invalid strobe synchroniser
	logic [7:0]           by_s1, by_s2;                 // byte synchroniser
	logic [3:0]           bc_s1, bc_s2;                 // bit count synchroniser
	logic                 bv_d, fe_d, iv_d;             // edge detect history
	logic                 byte_ev, frame_ev, inv_ev;    // one-cycle events
	logic                 setup_w, access;              // bus decode
	logic                 crc_clear;                    // crc preset at receive start
	logic [15:0]          crc_run;                      // running crc
	logic                 wr_mode, wr_cmd;              // write strobes
	logic                 active_reg;                   // receiver running, registered for the pin

	// two flip-flops on every demodulator pin, then edge history
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			bv_s1 <= 1'b0; bv_s2 <= 1'b0; fe_s1 <= 1'b0; fe_s2 <= 1'b0;
			iv_s1 <= 1'b0; iv_s2 <= 1'b0; by_s1 <= 8'h00; by_s2 <= 8'h00;
			bc_s1 <= 4'h0; bc_s2 <= 4'h0; bv_d <= 1'b0; fe_d <= 1'b0; iv_d <= 1'b0;
		end else begin
			bv_s1 <= rx_byte_valid; bv_s2 <= bv_s1; fe_s1 <= rx_frame_end; fe_s2 <= fe_s1;
			iv_s1 <= rx_invalid; iv_s2 <= iv_s1; by_s1 <= rx_byte; by_s2 <= by_s1;
			bc_s1 <= rx_bit_count; bc_s2 <= bc_s1; bv_d <= bv_s2; fe_d <= fe_s2; iv_d <= iv_s2;
		end
	end

	// rising edges of the synchronised strobes
	assign byte_ev  = bv_s2 & ~bv_d;
	assign frame_ev = fe_s2 & ~fe_d;
	assign inv_ev   = iv_s2 & ~iv_d;
	assign access   = psel & penable;
	assign setup_w  = access & pwrite;
	assign wr_mode  = setup_w && (paddr == nrmc_pkg::ADDR_RX_MODE);
	assign wr_cmd   = setup_w && (paddr == nrmc_pkg::ADDR_RX_CONTROL);

	// register file and bus answer: one wait state, unmapped address errors
	always_comb begin
		mode_next  = mode_reg;
		cmd_next   = cmd_reg;
		rdata_next = 32'h0000_0000;
		rdy_next   = 1'b0;
		err_next   = 1'b0;
		if (access && !rdy_reg) begin
			rdy_next = 1'b1;
			unique case (paddr)
				nrmc_pkg::ADDR_RX_MODE: begin
					if (pwrite) mode_next = pwdata[7:0];
					else rdata_next = {24'h00_0000, mode_reg};
				end
				nrmc_pkg::ADDR_RX_CONTROL: begin
					if (pwrite) cmd_next = pwdata[nrmc_pkg::CMD_MSB:0];
					else rdata_next = {28'h000_0000, cmd_reg};
				end
				nrmc_pkg::ADDR_RX_STATUS: begin
					if (!pwrite) rdata_next = {crcv_reg, 13'h0000, inv_reg, st_reg};
				end
				default: begin
					err_next = 1'b1;  // unmapped: error, writes dropped
				end
			endcase
		end
		// single frame mode: command returns to idle once the frame is done
		if (st_reg == nrmc_pkg::NRMC_DONE && !(wr_cmd && !rdy_reg)) begin
			cmd_next = nrmc_pkg::CMD_IDLE;  // [R3]
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			mode_reg  <= nrmc_pkg::MODE_RESET;
			cmd_reg   <= nrmc_pkg::CMD_IDLE;
			rdata_reg <= 32'h0000_0000;
			rdy_reg   <= 1'b0;
			err_reg   <= 1'b0;
		end else begin
			mode_reg  <= mode_next;
			cmd_reg   <= cmd_next;
			rdata_reg <= rdata_next;
			rdy_reg   <= rdy_next;
			err_reg   <= err_next;
		end
	end

	// receiver control: runs while receive or transceive is the command
	always_comb begin
		logic rx_cmd;
		logic multi;
		rx_cmd   = (cmd_reg == nrmc_pkg::CMD_RECEIVE) || (cmd_reg == nrmc_pkg::CMD_TRANSCEIVE);
		multi    = mode_reg[nrmc_pkg::BIT_MULTI];
		st_next  = st_reg;
		inv_next = inv_reg;
		crc_clear = 1'b0;
		unique case (st_reg)
			nrmc_pkg::NRMC_IDLE: begin
				if (rx_cmd) begin
					st_next   = nrmc_pkg::NRMC_ACTIVE;
					crc_clear = 1'b1;
				end
			end
			nrmc_pkg::NRMC_ACTIVE: begin
				if (!rx_cmd || (wr_cmd && !rdy_reg && pwdata[nrmc_pkg::CMD_MSB:0] != nrmc_pkg::CMD_RECEIVE)) begin
					// any code but receive ends reception; a fresh transceive restarts from idle
					st_next = nrmc_pkg::NRMC_IDLE;  // [R5]
				end else if (frame_ev) begin
					crc_clear = 1'b1;
					if (!multi) st_next = nrmc_pkg::NRMC_DONE;  // [R3]
					// otherwise keep accepting the next frame [R4]
				end else if (inv_ev && !(mode_reg[nrmc_pkg::BIT_IGN_SHORT]
						&& bc_s2 < 4'(nrmc_pkg::SHORT_BITS))) begin
					inv_next = 1'b1;  // [R2]
				end
			end
			nrmc_pkg::NRMC_DONE: begin
				st_next = nrmc_pkg::NRMC_IDLE;
			end
		endcase
		// continuous mode also ends when host clears the multiple bit mid-stream
		if (st_reg == nrmc_pkg::NRMC_ACTIVE && wr_mode && !rdy_reg
				&& mode_reg[nrmc_pkg::BIT_MULTI] && !pwdata[nrmc_pkg::BIT_MULTI]) begin
			st_next = nrmc_pkg::NRMC_DONE;  // [R5]
		end
		// write of a 1 to status bit clears the flag; a new event wins only while the flag is clear
		if (setup_w && !rdy_reg && paddr == nrmc_pkg::ADDR_RX_STATUS && pwdata[nrmc_pkg::BIT_INV_FLAG]
				&& inv_next == inv_reg) begin
			inv_next = 1'b0;
		end
	end

	// demodulator settings; reserved codes fall back to safe values
	always_comb begin
		logic [2:0] r;
		logic [1:0] f;
		r = mode_reg[nrmc_pkg::RATE_MSB:nrmc_pkg::RATE_LSB];
		f = mode_reg[nrmc_pkg::FRAME_MSB:nrmc_pkg::FRAME_LSB];
		rate_next = (r > nrmc_pkg::RATE_848) ? nrmc_pkg::RATE_106 : r;  // [R1]
		fb_next   = (f == nrmc_pkg::FRAME_TYPE_B);  // [R6]
		crcv_next = (frame_ev && st_reg == nrmc_pkg::NRMC_ACTIVE) ? crc_run : crcv_reg;
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			st_reg   <= nrmc_pkg::NRMC_IDLE;
			active_reg <= 1'b0;
			inv_reg  <= 1'b0;
			rate_reg <= nrmc_pkg::RATE_106;
			fb_reg   <= 1'b0;
			crcv_reg <= 16'h0000;
		end else begin
			st_reg   <= st_next;
			active_reg <= (st_next == nrmc_pkg::NRMC_ACTIVE);  // same timing as the state, no decode glitch
			inv_reg  <= inv_next;
			rate_reg <= rate_next;
			fb_reg   <= fb_next;
			crcv_reg <= crcv_next;
		end
	end

	// crc runs only on bytes of an active frame while enabled
	nrmc_crc u_crc (
		.clock      (clock),
		.arst_n     (arst_n),
		.clear      (crc_clear),
		.enable     (byte_ev && st_reg == nrmc_pkg::NRMC_ACTIVE && mode_reg[nrmc_pkg::BIT_CRC_EN]),  // [R7]
		.data       (by_s2),
		.preset_val (fb_reg ? nrmc_pkg::CRC_PRESET_B : nrmc_pkg::CRC_PRESET_A),
		.crc        (crc_run)
	);

	assign prdata          = rdata_reg;
	assign pready          = rdy_reg;
	assign pslverr         = err_reg;
	assign receiver_active = active_reg;
	assign rate_sel        = rate_reg;
	assign framing_b       = fb_reg;
	assign crc_on          = mode_reg[nrmc_pkg::BIT_CRC_EN];
	assign crc_value       = crcv_reg;
	assign invalid_flag    = inv_reg;
endmodule

//--- verification/nrmc_assertions.sv
// checker: apb answer and mode output relations of nrmc_top
`timescale 1ns/10ps
module nrmc_assertions (
	input wire logic        clock,
	input wire logic        arst_n,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        receiver_active,
	input wire logic [2:0]  rate_sel,
	input wire logic        framing_b,
	input wire logic        crc_on
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!arst_n);
	logic       mw;  // mode write completes
	logic       cw;  // command write completes
	logic [7:0] wv_q; // last mode value written
	assign mw = psel && penable && pready && pwrite && paddr == nrmc_pkg::ADDR_RX_MODE;
	assign cw = psel && penable && pready && pwrite && paddr == nrmc_pkg::ADDR_RX_CONTROL;
	// keep the written value, outputs may lag the register by a stage
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n)
			wv_q <= 8'h00;
		else if (mw)
			wv_q <= pwdata[7:0];
	end
	ready_wait_a: assert property (psel && penable && !pready |=> pready) else $error("no answer");
	ready_pulse_a: assert property (pready |=> !pready) else $error("pready too long");
	err_ready_a: assert property (pslverr |-> pready) else $error("pslverr alone");
	ready_cause_a: assert property (pready |-> $past(penable)) else $error("pready unasked");
	rate_range_a: assert property (!rate_sel[2]) else $error("reserved rate out");
	rate_code_a: assert property (mw |-> ##2 rate_sel == (wv_q[6] ? 3'h0 : wv_q[6:4])) else $error("rate");
	frame_code_a: assert property (mw |-> ##2 framing_b == (wv_q[1:0] == 2'h3)) else $error("framing");
	crc_bit_a: assert property (mw |-> ##2 crc_on == wv_q[7]) else $error("crc enable");
	stop_cmd_a: assert property (cw && pwdata[3:0] == nrmc_pkg::CMD_IDLE |-> ##[1:4] !receiver_active)
		else $error("no stop");
	mode_c: cover property (mw);
	recv_c: cover property (cw && pwdata[3:0] == nrmc_pkg::CMD_RECEIVE);
	stop_c: cover property ($fell(receiver_active));
endmodule
bind nrmc_top nrmc_assertions i_chk (.clock, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
	.pslverr, .receiver_active, .rate_sel, .framing_b, .crc_on);

//--- verification/nrmc_card_model.sv
// partner: card side as seen after the demodulator
`timescale 1ns/10ps
module nrmc_card_model (
	input wire logic  clock,
	output logic       rx_byte_valid,
	output logic [7:0] rx_byte,
	output logic       rx_frame_end,
	output logic       rx_invalid,
	output logic [3:0] rx_bit_count
);
	// quiet link at start
	initial begin
		rx_byte_valid = 1'b0;
		rx_byte = 8'h5a;
		rx_frame_end = 1'b0;
		rx_invalid = 1'b0;
		rx_bit_count = 4'h0;
	end
	// strobes held 3 clocks so the 2-flop sync sees them; gap makes a slow card
	task automatic send_byte(input logic [7:0] b, input int gap);
		rx_byte <= b;
		@(posedge clock) rx_byte_valid <= 1'b1;
		repeat (3) @(posedge clock);
		rx_byte_valid <= 1'b0;
		repeat (3) @(posedge clock);
		rx_byte <= ~b; // stale byte is not left on the line
		repeat (gap + 1) @(posedge clock);
	endtask
	task automatic end_frame();
		rx_frame_end <= 1'b1;
		repeat (3) @(posedge clock);
		rx_frame_end <= 1'b0;
		repeat (3) @(posedge clock);
	endtask
	// invalid burst of n bits, count set one edge ahead of the strobe
	task automatic burst(input logic [3:0] n);
		rx_bit_count <= n;
		@(posedge clock) rx_invalid <= 1'b1;
		repeat (3) @(posedge clock);
		rx_invalid <= 1'b0;
		rx_bit_count <= ~n;
		repeat (3) @(posedge clock);
	endtask
endmodule

//--- verification/tb_top.sv
// testbench: mode register and receiver control of nrmc_top
`timescale 1ns/10ps
module tb_top;
	logic        clock, arst_n, psel, penable, pwrite, pready, pslverr, er;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic        rx_byte_valid, rx_frame_end, rx_invalid, receiver_active, framing_b, crc_on, invalid_flag;
	logic [7:0]  rx_byte, v;
	logic [3:0]  rx_bit_count;
	logic [2:0]  rate_sel;
	logic [15:0] crc_value;
	int          fails, checks_done, i;
	nrmc_top i_nrmc_top (.clock, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.rx_byte_valid, .rx_byte, .rx_frame_end, .rx_invalid, .rx_bit_count, .receiver_active, .rate_sel,
		.framing_b, .crc_on, .crc_value, .invalid_flag);
	nrmc_card_model i_nrmc_card_model (.clock, .rx_byte_valid, .rx_byte, .rx_frame_end, .rx_invalid,
		.rx_bit_count);
	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end
	function automatic logic [2:0] rate_exp(logic [7:0] m);
		return m[6] ? 3'h0 : m[6:4]; // reserved codes fall back to 106
	endfunction
	function automatic logic [15:0] crc_step(logic [15:0] c, logic [7:0] b);
		c ^= {8'h00, b};
		repeat (8) c = c[0] ? (c >> 1) ^ 16'h8408 : c >> 1;
		return c;
	endfunction
	// one apb transfer; waits for pready under a bound
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock) penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		er = pslverr;
		if (n >= 20) begin
			fails++;
			$display("CHECK FAILED at %0t: no pready", $time);
		end
		psel <= 1'b0;
		penable <= 1'b0;
		repeat (4) @(posedge clock);
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checks_done++;
		if (g !== e) begin
			fails++;
			$display("CHECK FAILED at %0t: got %h want %h", $time, g, e);
		end
	endtask
	// random bytes from a slow or prompt card, crc worked out alongside
	task automatic frame(input int n, output logic [15:0] c, input logic [15:0] p = nrmc_pkg::CRC_PRESET_A);
		logic [7:0] b;
		c = p;
		repeat (n) begin
			b = 8'($urandom);
			c = crc_step(c, b);
			i_nrmc_card_model.send_byte(b, $urandom_range(0, 4));
		end
		i_nrmc_card_model.end_frame();
		repeat (6) @(posedge clock);
	endtask
	task automatic test_done();
		$display("checks %0d fails %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial begin
		#100us;
		fails++;
		$display("CHECK FAILED at %0t: watchdog expired", $time);
		test_done();
	end
	initial begin
		logic [15:0] c;
		arst_n = 1'b0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		void'($urandom(54709));
		repeat (10) @(posedge clock);
		arst_n <= 1'b1;
		@(posedge clock);
		apb(0, nrmc_pkg::ADDR_RX_MODE, 0);
		chk(rd, {24'h0, nrmc_pkg::MODE_RESET});
		apb(0, 12'h100, 0);
		chk({31'h0, er}, 1);
		chk(rd, 0);
		$display("test reset and unmapped done");
		for (i = 0; i < 16; i++) begin
			v = (i < 8) ? {i[0], i[2:0], 2'b00, i[1:0]} : 8'($urandom);
			apb(1, nrmc_pkg::ADDR_RX_MODE, {24'h0, v});
			apb(0, nrmc_pkg::ADDR_RX_MODE, 0);
			chk(rd, {24'h0, v});
			chk(rate_sel, rate_exp(v));
			chk(framing_b, v[1:0] == 2'b11);
			chk(crc_on, v[7]);
		end
		$display("test mode fields done");
		apb(1, nrmc_pkg::ADDR_RX_MODE, 32'h80);
		apb(1, nrmc_pkg::ADDR_RX_CONTROL, nrmc_pkg::CMD_RECEIVE);
		chk(receiver_active, 1);
		frame(3, c);
		chk(receiver_active, 0);
		chk(crc_value, c);
		apb(0, nrmc_pkg::ADDR_RX_CONTROL, 0);
		chk(rd[3:0], nrmc_pkg::CMD_IDLE);
		$display("test single frame done");
		apb(1, nrmc_pkg::ADDR_RX_MODE, 32'h84);
		apb(1, nrmc_pkg::ADDR_RX_CONTROL, nrmc_pkg::CMD_RECEIVE);
		frame(2, c);
		frame(1, c);
		chk(crc_value, c);
		chk(receiver_active, 1);
		apb(1, nrmc_pkg::ADDR_RX_CONTROL, nrmc_pkg::CMD_IDLE);
		chk(receiver_active, 0);
		apb(1, nrmc_pkg::ADDR_RX_CONTROL, nrmc_pkg::CMD_RECEIVE);
		apb(1, nrmc_pkg::ADDR_RX_MODE, 32'h80);
		chk(receiver_active, 0);
		$display("test multiple frame done");
		apb(1, nrmc_pkg::ADDR_RX_MODE, 32'h8c);
		apb(1, nrmc_pkg::ADDR_RX_CONTROL, nrmc_pkg::CMD_RECEIVE);
		i_nrmc_card_model.burst(4'h3);
		chk({invalid_flag, receiver_active}, 2'b01);
		i_nrmc_card_model.burst(4'h4);
		chk({invalid_flag, receiver_active}, 2'b11);
		apb(1, nrmc_pkg::ADDR_RX_STATUS, 32'h4);
		apb(1, nrmc_pkg::ADDR_RX_MODE, 32'h84);
		chk(invalid_flag, 0);
		i_nrmc_card_model.burst(4'h2);
		chk(invalid_flag, 1);
		apb(0, nrmc_pkg::ADDR_RX_STATUS, 0);
		chk(rd[2:0], 3'b101);
		$display("test short burst done");
		apb(1, nrmc_pkg::ADDR_RX_MODE, 32'h83);
		apb(1, nrmc_pkg::ADDR_RX_CONTROL, nrmc_pkg::CMD_TRANSCEIVE);
		chk(receiver_active, 1);
		frame(2, c, nrmc_pkg::CRC_PRESET_B);
		chk(receiver_active, 0);
		chk(crc_value, c);
		$display("test transceive type b done");
		test_done();
	end
endmodule
